// >>> core/cbu_branch.sv
// Conditional relative branch evaluation and fetch redirect
`timescale 1ns/1ns

module cbu_branch
  import cbu_pkg::*;
#(
  parameter int PW = cbu_pkg::PC_W
)
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Instruction from fetch
  input  wire cbu_pkg::cbu_req_s    req,
  input  wire logic [PW-1:0]        pc,
  // Status flags, read only
  input  wire cbu_pkg::cbu_flags_s  flags,
  // Results
  output      cbu_pkg::cbu_redirect_s redirect_q,
  output      logic                 busy_q,
  output      logic                 done_q,
  output      logic                 taken_q
);
  cbu_state_e          state_q;
  cbu_state_e          state_d;
  logic                is_branch;
  cbu_cond_e           cond;
  logic [PW-1:0]       offset;
  wire logic           accept;
  wire logic           cond_met;
  wire logic [PW-1:0]  target;
  wire logic           sel_zero_set;
  wire logic           sel_zero_clear;
  wire logic           sel_carry_set;
  wire logic           sel_carry_clear;
  wire logic           sel_neg_set;
  wire logic           sel_neg_clear;

  cbu_decode #(
    .PW        (PW)
  ) u_decode (
    .word      (req.word),
    .is_branch (is_branch),
    .cond      (cond),
    .offset    (offset)
  );

  // Requests during a redirect are dropped; fetch is stalled by busy_q
  assign accept = req.valid && is_branch && (state_q == ST_IDLE);

  assign sel_zero_set    = (cond == branch_on_zero_set);
  assign sel_zero_clear  = (cond == branch_on_zero_clear);
  assign sel_carry_set   = (cond == branch_on_carry_set) ||
                           (cond == branch_unsigned_lower);
  assign sel_carry_clear = (cond == branch_on_carry_clear) ||
                           (cond == branch_same_or_higher);
  assign sel_neg_set     = (cond == branch_on_negative_set);
  assign sel_neg_clear   = (cond == branch_on_negative_clear);

  assign cond_met = (sel_zero_set    &&  flags.z) ||
                    (sel_zero_clear  && !flags.z) ||
                    (sel_carry_clear && !flags.c) ||
                    (sel_carry_set   &&  flags.c) ||
                    (sel_neg_set     &&  flags.n) ||
                    (sel_neg_clear   && !flags.n);

  // Wraps modulo the counter width, like the fetch counter itself
  assign target = PW'(pc + offset + PW'(PC_ONE));

  // Taken branch holds one extra cycle so fetch can redirect
  assign state_d = (state_q == ST_REDIRECT) ? ST_IDLE :
                   (accept && cond_met)     ? ST_REDIRECT : ST_IDLE;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // No path writes the status flags: they are inputs only
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      redirect_q.load   <= 1'b0;
      redirect_q.target <= PW'(PC_RST);
      busy_q            <= 1'b0;
      done_q            <= 1'b0;
      taken_q           <= 1'b0;
    end
    else
    begin
      redirect_q.load <= accept && cond_met;
      if (accept)
        redirect_q.target <= cond_met ? target : PW'(pc + PW'(PC_ONE));
      busy_q  <= accept && cond_met;
      done_q  <= (accept && !cond_met) || (state_q == ST_REDIRECT);
      taken_q <= (state_q == ST_REDIRECT);
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_zero_set_take: assert property (
    accept && sel_zero_set |=> redirect_q.load == $past(flags.z))
    else $error("zero-set branch decision wrong");

  a_zero_clear_take: assert property (
    accept && sel_zero_clear |=> redirect_q.load == !$past(flags.z))
    else $error("zero-clear branch decision wrong");

  a_carry_clear_take: assert property (
    accept && (cond inside {branch_on_carry_clear, branch_same_or_higher})
    |=> redirect_q.load == !$past(flags.c))
    else $error("carry-clear or same-or-higher decision wrong");

  a_carry_set_take: assert property (
    accept && (cond inside {branch_on_carry_set, branch_unsigned_lower})
    |=> redirect_q.load == $past(flags.c))
    else $error("carry-set or lower decision wrong");

  a_neg_set_take: assert property (
    accept && sel_neg_set |=> redirect_q.load == $past(flags.n))
    else $error("negative-set branch decision wrong");

  a_neg_clear_take: assert property (
    accept && sel_neg_clear |=> redirect_q.load == !$past(flags.n))
    else $error("negative-clear branch decision wrong");

  a_branch_done_time: assert property (
    accept |-> ##[1:2] done_q)
    else $error("branch did not finish within two cycles");

  a_taken_target_seq: assert property (
    accept && cond_met |=> redirect_q.load && busy_q && !done_q &&
      redirect_q.target == PW'($past(pc) + $past(offset) + PW'(PC_ONE))
    ##1 done_q && taken_q && !busy_q && !redirect_q.load)
    else $error("taken branch target or two-cycle timing wrong");

  a_not_taken_one: assert property (
    accept && !cond_met |=> done_q && !taken_q && !busy_q && !redirect_q.load)
    else $error("not-taken branch took more than one cycle");

  c_taken_branch: cover property (accept && cond_met ##2 done_q);
  c_not_taken: cover property (accept && !cond_met ##1 done_q);
  c_back_to_back: cover property (accept && !cond_met ##1 accept);
  c_refused_busy: cover property (busy_q && req.valid && is_branch);

endmodule

// >>> core/cbu_decode.sv
// Instruction field decoder for the conditional branch unit
`timescale 1ns/1ns
module cbu_decode
  import cbu_pkg::*;
#(
  parameter int PW = cbu_pkg::PC_W
)
(
  // Instruction
  input  wire logic [cbu_pkg::INSTR_W-1:0] word,
  // Decoded fields
  output      logic                        is_branch,
  output      cbu_pkg::cbu_cond_e          cond,
  output      logic [PW-1:0]               offset
);
  wire logic [K_W-1:0] k_field;

  assign is_branch = (word[GRP_LSB +: GRP_W] == GRP_CODE);
  assign cond      = cbu_cond_e'(word[SEL_LSB +: SEL_W]);
  assign k_field   = word[K_LSB +: K_W];
  // Signed word offset, sign extended to the counter width
  assign offset    = {{(PW-K_W){k_field[K_W-1]}}, k_field};

endmodule

// >>> core/cbu_pkg.sv
// Shared constants and types for the conditional branch unit
package cbu_pkg;

  // Instruction word layout
  localparam int INSTR_W  = 16;
  localparam int GRP_LSB  = 10;
  localparam int GRP_W    = 6;
  localparam logic [GRP_W-1:0] GRP_CODE = 6'h3c;
  localparam int K_LSB    = 3;
  localparam int K_W      = 7;
  localparam int SEL_LSB  = 0;
  localparam int SEL_W    = 3;

  // Program counter
  localparam int PC_W     = 16;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 16'h0001;

  // Cycle counts of a branch
  localparam int NOT_TAKEN_CYCLES = 1;
  localparam int TAKEN_CYCLES     = 2;

  typedef enum logic [SEL_W-1:0] {
    branch_on_zero_set,
    branch_on_zero_clear,
    branch_on_carry_set,
    branch_on_carry_clear,
    branch_same_or_higher,
    branch_unsigned_lower,
    branch_on_negative_set,
    branch_on_negative_clear
  } cbu_cond_e;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_REDIRECT
  } cbu_state_e;

  typedef struct packed {
    logic z;
    logic c;
    logic n;
  } cbu_flags_s;

  typedef struct packed {
    logic               valid;
    logic [INSTR_W-1:0] word;
  } cbu_req_s;

  typedef struct packed {
    logic            load;
    logic [PC_W-1:0] target;
  } cbu_redirect_s;

endpackage

// >>> test/test_cbu_branch.sv
// Self-checking bench for the conditional branch unit
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module test_cbu_branch;
  import cbu_pkg::*;
  logic          clock;
  logic          rst_b;
  cbu_req_s      req;
  logic [15:0]   pc;
  cbu_flags_s    flags;
  cbu_redirect_s redirect_q;
  logic          busy_q;
  logic          done_q;
  logic          taken_q;
  int            err_count;
  int            compares;
  logic [9:0]    rows [8];
  logic [15:0]   p;
  logic          tk;

  cbu_branch i_dut (.clock(clock), .rst_b(rst_b), .req(req), .pc(pc), .flags(flags),
    .redirect_q(redirect_q), .busy_q(busy_q), .done_q(done_q), .taken_q(taken_q));

  initial
  begin
    clock = 0;
    forever #25 clock = ~clock;
  end

  task automatic send(input logic [2:0] c, input logic [6:0] k, input logic [15:0] a,
    input logic [2:0] f);
    @(posedge clock);
    req   <= '{1'b1, {GRP_CODE, k, c}};
    pc    <= a;
    flags <= f;
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_count++;
    end_sim;
  end

  initial
  begin
    req = '0;
    pc = '0;
    flags = '0;
    rst_b = 0;
    err_count = 0;
    compares = 0;
    // Flags that take each condition, with a signed offset
    rows = '{{3'h4, 7'h01}, {3'h3, 7'h7f}, {3'h2, 7'h40}, {3'h5, 7'h3f},
             {3'h5, 7'h10}, {3'h2, 7'h70}, {3'h1, 7'h00}, {3'h6, 7'h02}};
    repeat (12) @(posedge clock);
    `CHK({redirect_q, busy_q, done_q, taken_q}, 20'h0)
    rst_b <= 1;
    $display("reset test done");
    // Each row is sent twice: even passes take the branch, odd passes see inverted flags
    for (int i = 0; i < 16; i++)
    begin
      tk = !i[0];
      p = 16'hffc0 + 16'(i * 8);
      send(3'(i / 2), rows[i / 2][6:0], p, tk ? rows[i / 2][9:7] : ~rows[i / 2][9:7]);
      @(posedge clock);
      req.valid <= 0;
      #1 `CHK({redirect_q.load, busy_q, done_q, taken_q}, {tk, tk, !tk, 1'b0})
      `CHK(redirect_q.target, p + (tk ? {{9{rows[i / 2][6]}}, rows[i / 2][6:0]} : 16'h0) + 16'h1)
      if (tk)
      begin
        @(posedge clock);
        #1 `CHK({redirect_q.load, busy_q, done_q, taken_q}, 4'h3)
      end
    end
    $display("table test done");
    // Two not-taken branches back to back
    send(3'h1, 7'h05, 16'h0200, 3'h7);
    send(3'h0, 7'h05, 16'h0300, 3'h3);
    #1 `CHK({done_q, redirect_q.target}, {1'b1, 16'h0201})
    @(posedge clock);
    req.valid <= 0;
    #1 `CHK({done_q, redirect_q.target}, {1'b1, 16'h0301})
    $display("back to back test done");
    // Request during the redirect cycle must be dropped
    send(3'h6, 7'h04, 16'h0400, 3'h1);
    send(3'h0, 7'h01, 16'h0500, 3'h4);
    @(posedge clock);
    req.valid <= 0;
    #1 `CHK({done_q, taken_q, redirect_q.target}, {2'h3, 16'h0405})
    @(posedge clock);
    #1 `CHK({done_q, redirect_q.load, redirect_q.target}, {2'h0, 16'h0405})
    $display("refusal test done");
    // Word outside the branch group is ignored
    @(posedge clock);
    req <= '{1'b1, 16'h0000};
    @(posedge clock);
    req.valid <= 0;
    #1 `CHK({done_q, busy_q, redirect_q.load}, 3'h0)
    $display("non-branch test done");
    // Reset in the middle of a taken branch
    send(3'h0, 7'h02, 16'h0600, 3'h4);
    @(posedge clock);
    req.valid <= 0;
    rst_b <= 0;
    #1 `CHK({redirect_q, busy_q, done_q, taken_q}, 20'h0)
    @(posedge clock);
    rst_b <= 1;
    $display("mid-run reset test done");
    end_sim;
  end
endmodule
